// >>> spims_regs.svh
// Purpose: Bit positions, reset values and timing counts of the serial port
// Assumes: Included by bare name from the package and the modules
// Notes: Control and status layouts are fixed here and used by name in the port; the checker and bench use bare bit numbers
`ifndef SPIMS_REGS_SVH
`define SPIMS_REGS_SVH

// Control register fields
`define SPIMS_CR_IRQEN 7
`define SPIMS_CR_PEN 6
`define SPIMS_CR_RATE2 5
`define SPIMS_CR_MASTER_SELECT_BIT 4
`define SPIMS_CR_CPOL 3
`define SPIMS_CR_CPHA 2
`define SPIMS_CR_RATE1 1
`define SPIMS_CR_RATE0 0
`define SPIMS_CR_RESET 8'h00

// Control/status register fields
`define SPIMS_SR_DONE 7
`define SPIMS_SR_WRITE_COLLISION_FLAG 6
`define SPIMS_SR_OVR 5
`define SPIMS_SR_MODE_FAULT_FLAG 4
`define SPIMS_SR_SSM 1
`define SPIMS_SR_SSI 0
`define SPIMS_SR_RESET 8'h00

// Master clock rates: divide by 4 up to divide by 128
`define SPIMS_RATE_MAX 3'h5
`define SPIMS_HALF_MIN 7'h02
`define SPIMS_LAST_EDGE 4'hf
`define SPIMS_LAST_BIT 4'h7

`endif

// >>> spims_pkg.sv
// Purpose: Types of the serial port
// Assumes: Register layout header is on the include path
// Notes: Each module keeps all of its state in one packed struct
`include "spims_regs.svh"

package spims_pkg;

    // Main port state
    typedef struct packed {
        logic [7:0] ctrl;
        logic select_soft_manage;
        logic select_soft_level;
        logic done;
        logic write_collision_flag;
        logic overrun_flag;
        logic mode_fault_flag;
        logic doneArm;
        logic wcolArm;
        logic modfArm;
        logic [7:0] sh;
        logic [7:0] rx;
        logic outBit;
        logic busy;
        logic [3:0] edgeCnt;
        logic [3:0] bitCnt;
        logic sckLvl;
        logic [2:0] sckSync;
        logic [1:0] ssSync;
        logic [1:0] mosiSync;
    } spims_state_t;

    // Rate divider state
    typedef struct packed {
        logic [6:0] cnt;
    } spims_baud_t;

endpackage : spims_pkg

// >>> spims_baud.sv
// Purpose: Half-period tick generator for the master serial clock
// Assumes: rate codes above the last one behave as the slowest rate
// Notes: A tick comes every half serial period while run is high
`timescale 1ns/100ps
`include "spims_regs.svh"

module spims_baud import spims_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control
    input wire logic run,
    input wire logic [2:0] rate,
    // Tick
    output logic tick
);

    spims_baud_t q;
    spims_baud_t d;
    logic [2:0] code;
    logic [6:0] half;

    // Half period is two cycles shifted left by the rate code
    always_comb begin
        code = (rate > `SPIMS_RATE_MAX) ? `SPIMS_RATE_MAX : rate;
        half = `SPIMS_HALF_MIN << code;
        tick = run && (q.cnt == half - 7'h01);
        d = q;
        if (!run || tick) begin
            d.cnt = 7'h00;
        end else begin
            d.cnt = q.cnt + 7'h01;
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

endmodule : spims_baud

// >>> spims_port.sv
// Purpose: Full-duplex serial port acting as master or slave
// Assumes: Register access arrives as one-cycle strobes with data
// Notes: Slave-side pins are synchronised before edges are detected
// Function
// - One clock edge pair shifts one bit out and one bit in.
// - Bytes travel most significant bit first both ways.
// - Master starts every transfer; slave shifts only under master clock.
// - Six master clock rates, fastest one quarter of the system clock.
// - Master drives the clock pin; slave only receives it.
// - Master drives master-out line, slave drives slave-out line.
// - Active-low select pin addresses a slave as chip select.
// - Software sets rate, polarity and phase; four clock modes.
// - Soft-manage bit picks select pin or software select.
// - Under software select, internal level equals the written bit.
// - Phase-zero slave write with select still low flags collision.
// - Control, control/status and data registers are offered.
// - Done, fault and overrun flags can interrupt; collision flag exists.
// - Data write loads the shift register, sent most significant first.
// - Done sets per byte; status then data access clears it.
// - Master select driven low sets fault, clears enable and master.
// - Byte before done is cleared sets overrun and keeps first byte.
`timescale 1ns/100ps
`include "spims_regs.svh"

module spims_port import spims_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Control register access
    input wire logic ctrlWr,
    input wire logic [7:0] ctrlWdata,
    output logic [7:0] ctrlRdata,
    // Control/status register access
    input wire logic csrRd,
    input wire logic csrWr,
    input wire logic [7:0] csrWdata,
    output logic [7:0] csrRdata,
    // Data register access
    input wire logic dataRd,
    input wire logic dataWr,
    input wire logic [7:0] dataWdata,
    output logic [7:0] dataRdata,
    // Interrupt request
    output logic irq,
    // Serial clock pin
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOen,
    // Master-out line
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOen,
    // Master-in line
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOen,
    // Slave select pin
    input wire logic ssN
);

    spims_state_t q;
    spims_state_t d;
    logic tick;
    logic cpol;
    logic cpha;
    logic pen;
    logic master_select_bit;
    logic ssInt;
    logic slaveSel;
    logic sckEdge;
    logic sckLead;
    logic mEdge;
    logic mLead;
    logic sampleEv;
    logic shiftEv;
    logic inBit;
    logic complete;
    logic xferBusy;
    logic [7:0] newByte;
    logic [7:0] cv;

    // Master clock rate
    // six rate divider
    spims_baud i_spims_baud (
        .clock(clock),
        .nrst(nrst),
        .run(q.busy),
        .rate({q.ctrl[`SPIMS_CR_RATE2], q.ctrl[`SPIMS_CR_RATE1], q.ctrl[`SPIMS_CR_RATE0]}),
        .tick(tick)
    );

    // Next-state logic
    always_comb begin
        d = q;
        cv = ctrlWdata;
        cpol = q.ctrl[`SPIMS_CR_CPOL];
        cpha = q.ctrl[`SPIMS_CR_CPHA];
        pen = q.ctrl[`SPIMS_CR_PEN];
        master_select_bit = q.ctrl[`SPIMS_CR_MASTER_SELECT_BIT];
        d.sckSync = {q.sckSync[1:0], sckIn};
        d.ssSync = {q.ssSync[0], ssN};
        d.mosiSync = {q.mosiSync[0], mosiIn};
        ssInt = q.select_soft_manage ? q.select_soft_level : q.ssSync[1];
        slaveSel = pen && !master_select_bit && !ssInt;
        sckEdge = q.sckSync[2] ^ q.sckSync[1];
        sckLead = sckEdge && (q.sckSync[1] != cpol);
        mEdge = tick && q.busy && master_select_bit;
        mLead = mEdge && !q.edgeCnt[0];
        // slave shifts only on master clock
        if (master_select_bit) begin
            sampleEv = mEdge && (mLead ^ cpha);
            shiftEv = mEdge && !(mLead ^ cpha);
            inBit = misoIn;
        end else begin
            sampleEv = slaveSel && sckEdge && (sckLead ^ cpha);
            shiftEv = slaveSel && sckEdge && !(sckLead ^ cpha);
            inBit = q.mosiSync[1];
        end
        newByte = sampleEv ? {q.sh[6:0], inBit} : q.sh;
        if (master_select_bit) begin
            complete = mEdge && (q.edgeCnt == `SPIMS_LAST_EDGE);
        end else begin
            complete = sampleEv && (q.bitCnt == `SPIMS_LAST_BIT);
        end
        if (master_select_bit) begin
            xferBusy = q.busy;
        end else begin
            xferBusy = slaveSel && (cpha ? (q.bitCnt != 4'h0) : 1'b1);
        end

        // bit in and bit out per clock
        if (sampleEv) begin
            d.sh = {q.sh[6:0], inBit};
            d.bitCnt = q.bitCnt + 4'h1;
        end
        if (shiftEv) begin
            d.outBit = q.sh[7];
        end
        // master clock toggles per half period
        if (mEdge) begin
            d.edgeCnt = q.edgeCnt + 4'h1;
            d.sckLvl = !q.sckLvl;
        end
        if (!master_select_bit && !slaveSel) begin
            d.bitCnt = 4'h0;
        end
        if (complete) begin
            d.bitCnt = 4'h0;
            d.busy = 1'b0;
        end

        // Status register access arms the done clear; only a status read arms the collision and fault clears
        if ((csrRd || csrWr) && q.done) begin
            d.doneArm = 1'b1;
        end
        if (csrRd && q.write_collision_flag) begin
            d.wcolArm = 1'b1;
        end
        if (csrRd && q.mode_fault_flag) begin
            d.modfArm = 1'b1;
        end
        if (csrRd) begin
            d.overrun_flag = 1'b0;
        end
        if (csrWr) begin
            d.select_soft_manage = csrWdata[`SPIMS_SR_SSM];
            d.select_soft_level = csrWdata[`SPIMS_SR_SSI];
        end
        // data access after status clears done
        if ((dataRd || dataWr) && q.doneArm) begin
            d.done = 1'b0;
            d.doneArm = 1'b0;
        end
        if ((dataRd || dataWr) && q.wcolArm) begin
            d.write_collision_flag = 1'b0;
            d.wcolArm = 1'b0;
        end

        if (dataWr && !(q.done && !q.doneArm)) begin
            if (xferBusy) begin
                d.write_collision_flag = 1'b1;
            end else begin
                d.sh = dataWdata;
                d.outBit = dataWdata[7];
                if (pen && master_select_bit) begin
                    d.busy = 1'b1;
                    d.edgeCnt = 4'h0;
                    d.bitCnt = 4'h0;
                end
            end
        end

        if (complete) begin
            if (d.done) begin
                d.overrun_flag = 1'b1;
            end else begin
                d.rx = newByte;
                d.done = 1'b1;
            end
        end

        // fault clear sequence, enables locked otherwise
        if (ctrlWr) begin
            if (q.mode_fault_flag && !q.modfArm) begin
                cv[`SPIMS_CR_PEN] = 1'b0;
                cv[`SPIMS_CR_MASTER_SELECT_BIT] = 1'b0;
            end
            if (q.modfArm) begin
                d.mode_fault_flag = 1'b0;
                d.modfArm = 1'b0;
            end
            d.ctrl = cv;
        end
        if (pen && master_select_bit && !ssInt) begin
            d.mode_fault_flag = 1'b1;
            d.ctrl[`SPIMS_CR_PEN] = 1'b0;
            d.ctrl[`SPIMS_CR_MASTER_SELECT_BIT] = 1'b0;
            d.busy = 1'b0;
        end
        if (!d.ctrl[`SPIMS_CR_PEN] || !d.ctrl[`SPIMS_CR_MASTER_SELECT_BIT]) begin
            d.busy = 1'b0;
        end
        if (!d.busy) begin
            d.sckLvl = d.ctrl[`SPIMS_CR_CPOL];
        end
    end

    // State register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        ctrlRdata = q.ctrl;
        csrRdata = `SPIMS_SR_RESET;
        csrRdata[`SPIMS_SR_DONE] = q.done;
        csrRdata[`SPIMS_SR_WRITE_COLLISION_FLAG] = q.write_collision_flag;
        csrRdata[`SPIMS_SR_OVR] = q.overrun_flag;
        csrRdata[`SPIMS_SR_MODE_FAULT_FLAG] = q.mode_fault_flag;
        csrRdata[`SPIMS_SR_SSM] = q.select_soft_manage;
        csrRdata[`SPIMS_SR_SSI] = q.select_soft_level;
        dataRdata = q.rx;
    end

    assign irq = q.ctrl[`SPIMS_CR_IRQEN] && (q.done || q.overrun_flag || q.mode_fault_flag);

    // clock pin driven only as master
    assign sckOut = q.sckLvl;
    assign sckOen = !(q.ctrl[`SPIMS_CR_PEN] && q.ctrl[`SPIMS_CR_MASTER_SELECT_BIT]);
    assign mosiOut = q.outBit;
    assign mosiOen = sckOen;
    assign misoOut = q.outBit;
    assign misoOen = !(q.ctrl[`SPIMS_CR_PEN] && !q.ctrl[`SPIMS_CR_MASTER_SELECT_BIT] && !ssInt);

endmodule : spims_port

// >>> spims_port_assertions.sv
// Purpose: Port-level checks of the serial port
// Assumes: Bound to spims_port; one clock domain
// Notes: Transfer length is checked at the fastest master rate only
`timescale 1ns/100ps

module spims_port_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Strobes
    input wire logic dataWr,
    input wire logic csrRd,
    input wire logic dataRd,
    // Registers and pins
    input wire logic [7:0] ctrlRdata,
    input wire logic [7:0] csrRdata,
    input wire logic irq,
    input wire logic sckOut,
    input wire logic sckOen,
    input wire logic mosiOen,
    input wire logic misoOen,
    input wire logic ssN
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    logic mEn;

    // Master mode in force
    assign mEn = ctrlRdata[6] && ctrlRdata[4];

    property p_mDrv; mEn [*2] |-> !sckOen && !mosiOen; endproperty
    a_mDrv: assert property (p_mDrv) else $error("master pins not driven");
    property p_sDrv; !mEn [*2] |-> sckOen && mosiOen; endproperty
    a_sDrv: assert property (p_sDrv) else $error("non-master drives clock");
    property p_miso; (ctrlRdata[4] || !ctrlRdata[6]) [*2] |-> misoOen; endproperty
    a_miso: assert property (p_miso) else $error("slave-out driven wrongly");
    property p_idle; $rose(csrRdata[7]) && mEn |-> sckOut == ctrlRdata[3]; endproperty
    a_idle: assert property (p_idle) else $error("clock not at polarity");
    property p_irq; irq == (ctrlRdata[7] && (csrRdata[7] || csrRdata[5] || csrRdata[4]));
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_flt; mEn && (csrRdata[1] ? !csrRdata[0] : !ssN)
        |-> ##[1:4] csrRdata[4] && !ctrlRdata[6] && !ctrlRdata[4]; endproperty
    a_flt: assert property (p_flt) else $error("fault missed");
    property p_ovr; csrRd && csrRdata[5] |=> !csrRdata[5]; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not cleared");
    property p_done; csrRd && csrRdata[7] ##2 dataRd |=> !csrRdata[7]; endproperty
    a_done: assert property (p_done) else $error("done not cleared");
    property p_len; mEn && dataWr && csrRdata[7:4] == 4'h0 && ctrlRdata[1:0] == 2'h0
        && !ctrlRdata[5] |-> ##30 !csrRdata[7] ##[1:6] csrRdata[7]; endproperty
    a_len: assert property (p_len) else $error("byte length wrong");

    // Main scenarios
    c_mst: cover property ($rose(csrRdata[7]) && mEn);
    c_flt: cover property ($rose(csrRdata[4]));
    c_ovr: cover property ($rose(csrRdata[5]));
endmodule : spims_port_checker

bind spims_port spims_port_checker i_spims_port_checker (.clock, .nrst, .dataWr, .csrRd,
    .dataRd, .ctrlRdata, .csrRdata, .irq, .sckOut, .sckOen, .mosiOen, .misoOen, .ssN);

// >>> spims_partner.sv
// Purpose: Far-end serial master or slave
// Assumes: Bench routes the right data line into din
// Notes: Same shifter serves both roles
`timescale 1ns/100ps

module spims_partner (
    // Clock and line mode
    input wire logic clock,
    input wire logic cpol,
    input wire logic cpha,
    // Lines
    input wire logic sck,
    input wire logic din,
    output logic sckDrv,
    output logic dout,
    output logic ssNDrv
);
    logic [7:0] tx;
    logic [7:0] rx;
    int k;
    int edges;

    // Idle lines
    initial begin
        {sckDrv, dout, ssNDrv, tx} = 11'h100;
    end

    // Preload the next byte
    task load(input logic [7:0] b);
        tx = b;
        k = 0;
        edges = 0;
        dout = b[7];
    endtask : load

    always @(sck) begin
        if (edges < 16) begin
            edges++;
            if ((sck != cpol) ^ cpha) begin
                rx = {rx[6:0], din};
            end else begin
                k = k + !cpha;
                dout = k < 8 ? tx[7 - k] : !dout;
                k = k + cpha;
            end
        end
    end

    task xfer(input logic [7:0] b, input int half);
        sckDrv <= cpol;
        repeat (half) @(posedge clock);
        load(b);
        ssNDrv <= 1'b0;
        repeat (16) begin
            repeat (half) @(posedge clock);
            sckDrv <= !sckDrv;
        end
        repeat (half) @(posedge clock);
        ssNDrv <= 1'b1;
    endtask : xfer
endmodule : spims_partner

// >>> test_spims_port.sv
// Purpose: Self-checking bench of the serial port
// Assumes: Partner model plays the far master or slave
// Notes: Slave frames run at one sixteenth of the clock
`timescale 1ns/100ps

module test_spims_port;
    logic clock, nrst, ctrlWr, csrRd, csrWr, dataRd, dataWr;
    logic [7:0] ctrlWdata, csrWdata, dataWdata, ctrlRdata, csrRdata, dataRdata, b;
    logic irq, sckOut, sckOen, mosiOut, mosiOen, misoOut, misoOen, ssN;
    logic sck, mosi, miso, sckDrv, dout, ssNDrv, pinSelN, dutMaster, cpol, cpha;
    int errors, nCompared, w;

    // Pin resolution
    assign sck = sckOen ? sckDrv : sckOut;
    assign mosi = mosiOen ? dout : mosiOut;
    assign miso = misoOen ? dout : misoOut;
    assign ssN = ssNDrv & pinSelN;

    spims_port i_spims_port (.clock, .nrst, .ctrlWr, .ctrlWdata, .ctrlRdata, .csrRd, .csrWr,
        .csrWdata, .csrRdata, .dataRd, .dataWr, .dataWdata, .dataRdata, .irq, .sckIn(sck),
        .sckOut, .sckOen, .mosiIn(mosi), .mosiOut, .mosiOen, .misoIn(miso), .misoOut,
        .misoOen, .ssN);
    spims_partner i_spims_partner (.clock, .cpol, .cpha, .sck, .din(dutMaster ? mosi : miso),
        .sckDrv, .dout, .ssNDrv);

    // Clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = !clock;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        finishTest();
    end

    task idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    // One strobe: 0 ctrl wr, 1 csr wr, 2 data wr, 3 csr rd, 4 data rd
    task acc(input int r, input logic [7:0] d);
        @(posedge clock);
        {ctrlWr, csrWr, dataWr, csrRd, dataRd} <= 5'b10000 >> r;
        {ctrlWdata, csrWdata, dataWdata} <= {3{d}};
        @(posedge clock);
        {ctrlWr, csrWr, dataWr, csrRd, dataRd} <= 5'h00;
        @(negedge clock);
    endtask : acc

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errors++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task finishTest;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finishTest

    // Main sequence
    initial begin
        {nrst, ctrlWr, csrRd, csrWr, dataRd, dataWr} = 6'h00;
        {ctrlWdata, csrWdata, dataWdata} = 24'h000000;
        {pinSelN, dutMaster, cpol, cpha} = 4'hc;
        {errors, nCompared} = 64'h0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        idle(1);
        chk(ctrlRdata, 8'h00);
        chk({irq, sckOen, mosiOen, misoOen, csrRdata[3:0]}, 8'h70);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            {cpol, cpha} = 2'(i);
            b = 8'ha5 + 8'(i);
            acc(1, 8'h03);
            acc(0, {2'b11, i[2], 1'b1, i[1:0], i[1:0]});
            i_spims_partner.load(~b);
            acc(2, b);
            w = 0;
            while (w < 3000 && csrRdata[7] !== 1'b1) begin
                idle(1);
                w++;
            end
            // Eight serial periods of four clocks, shifted by the rate code
            chk(8'(w >> i), 8'h20);
            chk(8'(w), 8'(32 << i));
            chk(csrRdata, 8'h83);
            chk(8'(irq), 8'h01);
            chk(i_spims_partner.rx, b);
            acc(2, 8'h00);
            idle(40);
            chk(8'(i_spims_partner.edges), 8'h10);
            acc(3, 8'h00);
            acc(4, 8'h00);
            chk(dataRdata, ~b);
            chk(8'(irq), 8'h00);
            chk(csrRdata, 8'h03);
            $display("test master mode %0d done", i);
        end
        acc(1, 8'h02);
        idle(4);
        chk(csrRdata, 8'h12);
        chk(ctrlRdata, 8'ha5);
        acc(1, 8'h00);
        acc(3, 8'h00);
        acc(0, 8'hd0);
        chk(csrRdata | ctrlRdata, 8'hd0);
        @(posedge clock) pinSelN <= 1'b0;
        idle(6);
        chk(csrRdata | ctrlRdata, 8'h90);
        @(posedge clock) pinSelN <= 1'b1;
        acc(3, 8'h00);
        acc(0, 8'hc0);
        $display("test fault done");
        {dutMaster, cpol, cpha} = 3'h0;
        acc(2, 8'h96);
        i_spims_partner.xfer(8'h5a, 8);
        chk(i_spims_partner.rx, 8'h96);
        acc(3, 8'h00);
        acc(4, 8'h00);
        chk(dataRdata, 8'h5a);
        i_spims_partner.xfer(8'h11, 8);
        i_spims_partner.xfer(8'h22, 8);
        idle(4);
        chk(csrRdata, 8'ha0);
        acc(3, 8'h00);
        acc(4, 8'h00);
        chk(dataRdata, 8'h11);
        @(posedge clock) pinSelN <= 1'b0;
        idle(4);
        chk(8'(misoOen), 8'h00);
        acc(2, 8'h77);
        chk(8'(irq), 8'h00);
        chk(csrRdata, 8'h40);
        $display("test slave done");
        // Phase-one slave, polarity high, select low over the whole byte
        @(posedge clock) pinSelN <= 1'b1;
        acc(3, 8'h00);
        acc(4, 8'h00);
        {cpol, cpha} = 2'h3;
        acc(0, 8'hcc);
        acc(2, 8'h3c);
        i_spims_partner.xfer(8'hc3, 8);
        chk(i_spims_partner.rx, 8'h3c);
        chk(csrRdata, 8'h80);
        acc(3, 8'h00);
        acc(4, 8'h00);
        chk(dataRdata, 8'hc3);
        $display("test slave phase one done");
        finishTest();
    end
endmodule : test_spims_port
